// file: hdl/drs_map.vh
// Constants for the dual breaker reclose sequencer
// Function
// - In second-first order with the second breaker inhibited and redirect-second-to-first set, close the first breaker at once.
// - In second-first order with redirect-second-to-first clear, hold the close while the second inhibit stands.
// - In first-second order with fail action Continue, a failed first close hands the close to the second breaker.
// - In first-second order with fail action Lockout, a failed first close goes to lockout with no second attempt.
// - In second-first order with fail action Continue, a failed second close hands the close to the first breaker.
// - In second-first order with fail action Lockout, a failed second close goes to lockout with no first attempt.
// - The order select offers first only, second only, both together, first-then-second and second-then-first.
// - The handover delay is used only for the two sequential orders.
// - The handover delay starts when the close goes to the leading breaker.
// - On handover expiry the close moves from the leading breaker to the trailing one.
// - A protection trip inside the handover delay stops the transfer to the trailing breaker, unless a Continue lead failure comes in the same cycle.
// - In first-second order with the first breaker inhibited, redirect-first-to-second set closes the second at once, else hold.
// - The shot timeout runs from initiation until a close is sent and forces lockout on expiry.
// - Each breaker inhibit gates that breaker's close output; in both-together order either inhibit holds the close of both breakers.
`ifndef DRS_MAP_VH
`define DRS_MAP_VH

// ==========================================================
// Clock and tick timing
`define DRS_CLK_PERIOD_NS 10
`define DRS_TICK_PERIOD_NS 1000000

// ==========================================================
// Register byte offsets
`define DRS_ADDR_W 8
`define DRS_OFS_CTRL 8'h00
`define DRS_OFS_HANDOVER 8'h04
`define DRS_OFS_TIMEOUT 8'h08
`define DRS_OFS_CMD 8'h0c
`define DRS_OFS_STATUS 8'h10

// ==========================================================
// Control fields
`define DRS_CTRL_ORDER_LSB 0
`define DRS_CTRL_ORDER_MSB 2
`define DRS_CTRL_REDIR12 3
`define DRS_CTRL_REDIR21 4
`define DRS_CTRL_FAIL1 5
`define DRS_CTRL_FAIL2 6
`define DRS_CTRL_W 7
`define DRS_CTRL_RST 7'h00
`define DRS_CMD_INIT 0
`define DRS_CMD_RESET 1
`define DRS_TIME_W 16
`define DRS_HANDOVER_RST 16'h0064
`define DRS_TIMEOUT_RST 16'h03e8

// ==========================================================
// Breaker order codes
`define DRS_ORD_FIRST 3'h0
`define DRS_ORD_SECOND 3'h1
`define DRS_ORD_BOTH 3'h2
`define DRS_ORD_1_2 3'h3
`define DRS_ORD_2_1 3'h4

// ==========================================================
// Data path widths and breaker indices
`define DRS_DATA_W 32
`define DRS_STATUS_W 6
`define DRS_NUM_BRK 2
`define DRS_BRK_FIRST 0
`define DRS_BRK_SECOND 1

`endif

// file: hdl/drs_sequencer.v
// Two-breaker reclose sequencer with APB register access
`timescale 1ns/10ps
`include "drs_map.vh"

module drs_sequencer #(
    parameter TICK_CYCLES = `DRS_TICK_PERIOD_NS / `DRS_CLK_PERIOD_NS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire reclose_initiate,
    input wire scheme_reset,
    input wire first_breaker_inhibit_input,
    input wire second_breaker_inhibit,
    input wire first_close_failed,
    input wire second_close_failed,
    input wire protection_trip,
    output reg close_first,
    output reg close_second,
    output reg lockout
);

// ==========================================================
// Register storage
reg [`DRS_CTRL_W-1:0] ctrl_reg;
reg [`DRS_TIME_W-1:0] handover_delay_reg;
reg [`DRS_TIME_W-1:0] shot_timeout_reg;
reg cmd_init_reg;
reg cmd_reset_reg;

wire apb_access;
wire apb_write;
wire [`DRS_ADDR_W-1:0] reg_addr;
wire addr_hit;

// ==========================================================
// Sequencer storage
reg [2:0] state_reg;
reg [2:0] state_next;
reg [`DRS_TIME_W-1:0] shot_ms_reg;
reg [`DRS_TIME_W-1:0] handover_ms_reg;
reg [31:0] tick_cnt_reg;
reg tick_reg;
reg close_first_next;
reg close_second_next;

wire [2:0] breaker_order_select;
wire redirect_first_to_second;
wire redirect_second_to_first;
wire first_breaker_fail_action;
wire second_breaker_fail_action;
wire sequential;
wire lead_is_second;
wire lead_inhibit;
wire trail_inhibit;
wire lead_failed;
wire trail_failed;
wire redirect_lead;
wire lead_fail_lockout;
wire shot_expired;
wire handover_expired;
wire start_cycle;
wire reset_cycle;
wire state_change;
wire closed_uses_first;
wire closed_uses_second;
wire closed_failed;
wire [`DRS_NUM_BRK-1:0] breaker_inhibit;
wire [`DRS_NUM_BRK-1:0] close_want;
wire [`DRS_NUM_BRK-1:0] close_gated;
reg [31:0] read_data_next;

// ==========================================================
// Sequencer states
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_WAIT = 3'h1;
localparam [2:0] ST_LEAD = 3'h2;
localparam [2:0] ST_TRAIL = 3'h3;
localparam [2:0] ST_CLOSED = 3'h4;
localparam [2:0] ST_LOCKOUT = 3'h5;
localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

assign breaker_order_select = ctrl_reg[`DRS_CTRL_ORDER_MSB:`DRS_CTRL_ORDER_LSB];
assign redirect_first_to_second = ctrl_reg[`DRS_CTRL_REDIR12];
assign redirect_second_to_first = ctrl_reg[`DRS_CTRL_REDIR21];
assign first_breaker_fail_action = ctrl_reg[`DRS_CTRL_FAIL1];
assign second_breaker_fail_action = ctrl_reg[`DRS_CTRL_FAIL2];

// ==========================================================
// APB decode
assign apb_access = psel & penable & pready;
assign apb_write = apb_access & pwrite;
assign reg_addr = paddr[`DRS_ADDR_W-1:0];
assign addr_hit = (paddr[31:`DRS_ADDR_W] == 24'h000000) &&
                  ((reg_addr == `DRS_OFS_CTRL) || (reg_addr == `DRS_OFS_HANDOVER) ||
                   (reg_addr == `DRS_OFS_TIMEOUT) || (reg_addr == `DRS_OFS_CMD) ||
                   (reg_addr == `DRS_OFS_STATUS));

// ==========================================================
// Read data select
// Unmapped, write-only and upper-address hits all read as zero
always @* begin
    read_data_next = 32'h00000000;
    if (addr_hit) begin
        case (reg_addr)
            `DRS_OFS_CTRL: begin
                read_data_next = {{(`DRS_DATA_W-`DRS_CTRL_W){1'h0}}, ctrl_reg};
            end
            `DRS_OFS_HANDOVER: begin
                read_data_next = {{(`DRS_DATA_W-`DRS_TIME_W){1'h0}}, handover_delay_reg};
            end
            `DRS_OFS_TIMEOUT: begin
                read_data_next = {{(`DRS_DATA_W-`DRS_TIME_W){1'h0}}, shot_timeout_reg};
            end
            `DRS_OFS_STATUS: begin
                read_data_next = {{(`DRS_DATA_W-`DRS_STATUS_W){1'h0}}, lockout, close_second, close_first, state_reg};
            end
            default: begin
                read_data_next = 32'h00000000;
            end
        endcase
    end
end

// One wait state keeps pready and prdata both registered
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~addr_hit;
        prdata <= (psel & penable & ~pready & ~pwrite) ? read_data_next : 32'h00000000;
    end
end

// ==========================================================
// Settings and command pulses
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `DRS_CTRL_RST;
        handover_delay_reg <= `DRS_HANDOVER_RST;
        shot_timeout_reg <= `DRS_TIMEOUT_RST;
        cmd_init_reg <= 1'b0;
        cmd_reset_reg <= 1'b0;
    end else begin
        cmd_init_reg <= 1'b0;
        cmd_reset_reg <= 1'b0;
        if (apb_write && addr_hit) begin
            case (reg_addr)
                `DRS_OFS_CTRL: begin
                    ctrl_reg <= pwdata[`DRS_CTRL_W-1:0];
                end
                `DRS_OFS_HANDOVER: begin
                    handover_delay_reg <= pwdata[`DRS_TIME_W-1:0];
                end
                `DRS_OFS_TIMEOUT: begin
                    shot_timeout_reg <= pwdata[`DRS_TIME_W-1:0];
                end
                `DRS_OFS_CMD: begin
                    cmd_init_reg <= pwdata[`DRS_CMD_INIT];
                    cmd_reset_reg <= pwdata[`DRS_CMD_RESET];
                end
                default: begin
                    cmd_init_reg <= 1'b0;
                end
            endcase
        end
    end
end

// ==========================================================
// Millisecond tick
// Free-running tick, so a timer may end up to one tick early
// common ms tick
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt_reg <= 32'h00000000;
        tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= 32'h00000000;
        tick_reg <= 1'b1;
    end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        tick_reg <= 1'b0;
    end
end

// ==========================================================
// Order decode
// five order values
assign sequential = (breaker_order_select == `DRS_ORD_1_2) || (breaker_order_select == `DRS_ORD_2_1);
assign lead_is_second = (breaker_order_select == `DRS_ORD_SECOND) || (breaker_order_select == `DRS_ORD_2_1);
assign lead_inhibit = (breaker_order_select == `DRS_ORD_BOTH) ?
                      (first_breaker_inhibit_input | second_breaker_inhibit) :
                      (lead_is_second ? second_breaker_inhibit : first_breaker_inhibit_input);
assign trail_inhibit = lead_is_second ? first_breaker_inhibit_input : second_breaker_inhibit;
assign lead_failed = lead_is_second ? second_close_failed : first_close_failed;
assign trail_failed = lead_is_second ? first_close_failed : second_close_failed;
assign redirect_lead = lead_is_second ? redirect_second_to_first : redirect_first_to_second;
assign lead_fail_lockout = lead_is_second ? second_breaker_fail_action : first_breaker_fail_action;
// Both-order close watches both breakers; spare codes act as first only
assign closed_uses_first = (breaker_order_select != `DRS_ORD_SECOND);
assign closed_uses_second = (breaker_order_select == `DRS_ORD_SECOND) || (breaker_order_select == `DRS_ORD_BOTH);
assign closed_failed = (closed_uses_first & first_close_failed) | (closed_uses_second & second_close_failed);

assign shot_expired = (shot_ms_reg >= shot_timeout_reg);
assign handover_expired = (handover_ms_reg >= handover_delay_reg);
assign start_cycle = reclose_initiate | cmd_init_reg;
assign reset_cycle = scheme_reset | cmd_reset_reg;
assign state_change = (state_next != state_reg);

// ==========================================================
// Sequencer next state
always @* begin
    state_next = state_reg;
    close_first_next = 1'b0;
    close_second_next = 1'b0;
    case (state_reg)
        ST_IDLE: begin
            if (start_cycle) begin
                state_next = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (!lead_inhibit) begin
                state_next = sequential ? ST_LEAD : ST_CLOSED;
            end else if (sequential && redirect_lead && !trail_inhibit) begin
                state_next = ST_TRAIL;
            end else if (shot_expired) begin
                state_next = ST_LOCKOUT;
            end
        end
        ST_LEAD: begin
            if (lead_failed) begin
                state_next = lead_fail_lockout ? ST_LOCKOUT : ST_TRAIL;
            end else if (protection_trip) begin
                state_next = ST_LOCKOUT;
            end else if (handover_expired) begin
                state_next = ST_TRAIL;
            end
        end
        ST_TRAIL: begin
            // No breaker left to fall back on
            if (trail_failed || protection_trip) begin
                state_next = ST_LOCKOUT;
            end
        end
        ST_CLOSED: begin
            if (closed_failed || protection_trip) begin
                state_next = ST_LOCKOUT;
            end
        end
        ST_LOCKOUT: begin
            state_next = ST_LOCKOUT;
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
    if (reset_cycle) begin
        state_next = ST_IDLE;
    end
    case (state_next)
        ST_LEAD: begin
            close_first_next = ~lead_is_second;
            close_second_next = lead_is_second;
        end
        ST_TRAIL: begin
            close_first_next = lead_is_second;
            close_second_next = ~lead_is_second;
        end
        ST_CLOSED: begin
            close_first_next = closed_uses_first;
            close_second_next = closed_uses_second;
        end
        default: begin
            close_first_next = 1'b0;
            close_second_next = 1'b0;
        end
    endcase
end

// ==========================================================
// Per-breaker inhibit gate
assign breaker_inhibit = {second_breaker_inhibit, first_breaker_inhibit_input};
assign close_want = {close_second_next, close_first_next};
genvar brk_i;
generate
    for (brk_i = 0; brk_i < `DRS_NUM_BRK; brk_i = brk_i + 1) begin : g_brk_gate
        assign close_gated[brk_i] = close_want[brk_i] & ~breaker_inhibit[brk_i];
    end
endgenerate

// ==========================================================
// Sequencer registers and timers
// Timers restart on every state change so a stale count never leaks
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= ST_IDLE;
        shot_ms_reg <= 16'h0000;
        handover_ms_reg <= 16'h0000;
        close_first <= 1'b0;
        close_second <= 1'b0;
        lockout <= 1'b0;
    end else begin
        state_reg <= state_next;
        close_first <= close_gated[`DRS_BRK_FIRST];
        close_second <= close_gated[`DRS_BRK_SECOND];
        lockout <= (state_next == ST_LOCKOUT);
        // shot timeout counts only while waiting
        if (state_change || state_reg != ST_WAIT) begin
            shot_ms_reg <= 16'h0000;
        end else if (tick_reg && !shot_expired) begin
            shot_ms_reg <= shot_ms_reg + 16'h0001;
        end
        if (state_change || state_reg != ST_LEAD) begin
            handover_ms_reg <= 16'h0000;
        end else if (tick_reg && !handover_expired) begin
            handover_ms_reg <= handover_ms_reg + 16'h0001;
        end
    end
end

endmodule

// file: tb/drs_sequencer_sva.sv
// Port assertions for the two-breaker reclose sequencer
`timescale 1ns/10ps
module drs_sequencer_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scheme_reset,
    input wire first_breaker_inhibit_input,
    input wire second_breaker_inhibit,
    input wire first_close_failed,
    input wire second_close_failed,
    input wire protection_trip,
    input wire close_first,
    input wire close_second,
    input wire lockout
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Bus answer
    chk_ready_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
    chk_ready_single: assert property (pready |=> !pready) else $error("ready held");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stale read data");
    // ==========================================
    // Sequencer outputs
    chk_inhibit_first: assert property (first_breaker_inhibit_input |-> ##1 !close_first) else $error("close 1");
    chk_inhibit_second: assert property (second_breaker_inhibit |-> ##1 !close_second) else $error("close 2");
    chk_lockout_holds: assert property (lockout && !scheme_reset |=> lockout) else $error("lockout left");
    chk_lockout_quiet: assert property (lockout |-> !close_first && !close_second) else $error("close in lockout");
    chk_reset_to_idle: assert property (scheme_reset |=> !lockout && !close_first && !close_second) else $error("rst");
    // Trip while a close stands and no close has failed ends the cycle
    chk_trip_lockout: assert property ((close_first || close_second) && protection_trip && !first_close_failed
        && !second_close_failed && !scheme_reset |=> lockout) else $error("trip ignored");
    cover property ($rose(lockout));
    cover property ($rose(close_second) && !close_first);
    cover property (pslverr);
endmodule

// file: tb/drs_breaker_model.sv
// Two breakers answering the close commands
`timescale 1ns/10ps
module drs_breaker_model (
    input wire close_first,
    input wire close_second,
    input wire fail_first_en,
    input wire fail_second_en,
    input wire trip_en,
    output wire first_close_failed,
    output wire second_close_failed,
    output wire protection_trip
);
    assign first_close_failed = close_first & fail_first_en;
    assign second_close_failed = close_second & fail_second_en;
    // permanent fault trips all poles again
    assign protection_trip = trip_en & (close_first | close_second);
endmodule

// file: tb/drs_sequencer_tb_top.sv
// Testbench for the two-breaker reclose sequencer
`timescale 1ns/10ps
`include "drs_map.vh"
module drs_sequencer_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic reclose_initiate, scheme_reset, inh1, inh2, f1_en, f2_en, trip_en;
    logic close_first, close_second, lockout;
    wire first_close_failed, second_close_failed, protection_trip;
    integer fails = 0;
    integer compares = 0;
    // Short tick keeps millisecond timers a few cycles long
    drs_sequencer #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reclose_initiate(reclose_initiate), .scheme_reset(scheme_reset), .first_breaker_inhibit_input(inh1),
        .second_breaker_inhibit(inh2), .first_close_failed(first_close_failed),
        .second_close_failed(second_close_failed), .protection_trip(protection_trip),
        .close_first(close_first), .close_second(close_second), .lockout(lockout));
    drs_breaker_model brk (.close_first(close_first), .close_second(close_second), .fail_first_en(f1_en),
        .fail_second_en(f2_en), .trip_en(trip_en), .first_close_failed(first_close_failed),
        .second_close_failed(second_close_failed), .protection_trip(protection_trip));
    // ==========================================
    // Shared tasks
    task close_out;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp) begin
                fails++;
                $display("[ERR] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            // No cycle count assumed; only the watchdog ends a hung access
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata; er = pslverr;
            psel <= 1'b0; penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        begin
            apb(1'b0, a, 32'h0);
            chk("read data", rd, exp);
            chk("read error", {31'h0, er}, {31'h0, experr});
        end
    endtask
    // One reclose cycle: stim = inh1 inh2 fail1 fail2 trip, outputs = first second lockout
    task scen(input logic [6:0] ctrl, input logic [4:0] stim, input logic [2:0] mid, input logic [2:0] fin);
        begin
            apb(1'b1, `DRS_OFS_CTRL, {25'h0, ctrl});
            {inh1, inh2, f1_en, f2_en, trip_en} <= stim;
            reclose_initiate <= 1'b1;
            @(posedge pclk);
            reclose_initiate <= 1'b0;
            repeat (6) @(posedge pclk);
            chk("outputs early", {29'h0, close_first, close_second, lockout}, {29'h0, mid});
            repeat (60) @(posedge pclk);
            chk("outputs late", {29'h0, close_first, close_second, lockout}, {29'h0, fin});
            scheme_reset <= 1'b1;
            {inh1, inh2, f1_en, f2_en, trip_en} <= 5'h00;
            repeat (2) @(posedge pclk);
            scheme_reset <= 1'b0;
            @(posedge pclk);
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100000;
        fails++;
        close_out();
    end
    // ==========================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, reclose_initiate, scheme_reset} = 6'h00;
        {inh1, inh2, f1_en, f2_en, trip_en} = 5'h00;
        paddr = 32'h0; pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`DRS_OFS_CTRL, 32'h0, 1'b0);
        rdchk(`DRS_OFS_HANDOVER, 32'h64, 1'b0);
        rdchk(`DRS_OFS_TIMEOUT, 32'h3e8, 1'b0);
        rdchk(8'h14, 32'h0, 1'b1);
        apb(1'b1, `DRS_OFS_STATUS, 32'hffffffff);
        rdchk(`DRS_OFS_STATUS, 32'h0, 1'b0);
        rdchk(`DRS_OFS_CMD, 32'h0, 1'b0);
        apb(1'b1, `DRS_OFS_HANDOVER, 32'h3);
        apb(1'b1, `DRS_OFS_TIMEOUT, 32'h5);
        rdchk(`DRS_OFS_HANDOVER, 32'h3, 1'b0);
        scen({4'h0, `DRS_ORD_FIRST}, 5'h00, 3'h4, 3'h4);
        scen({4'h0, `DRS_ORD_FIRST}, 5'h08, 3'h4, 3'h4);
        scen({4'h0, `DRS_ORD_SECOND}, 5'h00, 3'h2, 3'h2);
        scen({4'h0, `DRS_ORD_BOTH}, 5'h00, 3'h6, 3'h6);
        scen({4'h0, `DRS_ORD_1_2}, 5'h00, 3'h4, 3'h2);
        scen({4'h0, `DRS_ORD_2_1}, 5'h00, 3'h2, 3'h4);
        scen({4'h0, `DRS_ORD_1_2}, 5'h04, 3'h2, 3'h2);
        scen({4'h4, `DRS_ORD_1_2}, 5'h04, 3'h1, 3'h1);
        scen({4'h0, `DRS_ORD_2_1}, 5'h02, 3'h4, 3'h4);
        scen({4'h8, `DRS_ORD_2_1}, 5'h02, 3'h1, 3'h1);
        scen({4'h2, `DRS_ORD_2_1}, 5'h08, 3'h4, 3'h4);
        scen({4'h0, `DRS_ORD_2_1}, 5'h08, 3'h0, 3'h1);
        scen({4'h1, `DRS_ORD_1_2}, 5'h10, 3'h2, 3'h2);
        scen({4'h0, `DRS_ORD_1_2}, 5'h10, 3'h0, 3'h1);
        scen({4'h0, `DRS_ORD_1_2}, 5'h01, 3'h1, 3'h1);
        scen({4'h0, 3'h5}, 5'h00, 3'h4, 3'h4);
        scen({4'h0, `DRS_ORD_BOTH}, 5'h02, 3'h1, 3'h1);
        // Command register start and reset, seen through the status word
        apb(1'b1, `DRS_OFS_CTRL, {25'h0, `DRS_ORD_FIRST});
        apb(1'b1, `DRS_OFS_CMD, 32'h1);
        rdchk(`DRS_OFS_STATUS, 32'h0c, 1'b0);
        apb(1'b1, `DRS_OFS_CMD, 32'h2);
        rdchk(`DRS_OFS_STATUS, 32'h0, 1'b0);
        close_out();
    end
endmodule
bind drs_sequencer drs_sequencer_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scheme_reset(scheme_reset),
    .first_breaker_inhibit_input(first_breaker_inhibit_input), .second_breaker_inhibit(second_breaker_inhibit),
    .first_close_failed(first_close_failed), .second_close_failed(second_close_failed),
    .protection_trip(protection_trip), .close_first(close_first), .close_second(close_second), .lockout(lockout));
